// >>> common/sra_defs.svh
// Purpose: named constants of the serial readout converter sequencer
// Assumes: 25 MHz system clock; serial clock sampled, never used as a clock
// Notes:   edge numbers count serial clock falling edges after select falls
`ifndef SRA_DEFS_SVH
`define SRA_DEFS_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define SRA_RES_W        14
`define SRA_DAC_MSB      14'h2000
`define SRA_CNT_W        5

// ----------------------------------------------------------------
// falling-edge schedule (count of edges already seen)
// ----------------------------------------------------------------
`define SRA_CNT_SIXTH    5'h05
`define SRA_CNT_DEC_LO   5'h06
`define SRA_CNT_DEC_LSB  5'h13
`define SRA_CNT_SUB_HI   5'h14
`define SRA_CNT_SUB_LO   5'h15
`define SRA_CNT_OUT_LO   5'h07
`define SRA_CNT_OUT_HI   5'h16
`define SRA_CNT_LAST     5'h18

// ----------------------------------------------------------------
// host timing
// ----------------------------------------------------------------
`define SRA_CLK_NS       40
`define SRA_TACQ_NS      1100
`define SRA_SCLK_MAX_KHZ 4800
`define SRA_ACQ_CYC      ((`SRA_TACQ_NS + `SRA_CLK_NS - 1) / `SRA_CLK_NS)
`define SRA_SCLK_MIN_CYC ((1000000 + `SRA_SCLK_MAX_KHZ * `SRA_CLK_NS - 1) / (`SRA_SCLK_MAX_KHZ * `SRA_CLK_NS))
`define SRA_ACQ_CNT_W    6
`define SRA_GAP_CNT_W    4

`endif

// >>> common/sra_pkg.sv
// Purpose: types shared by the serial readout converter sequencer
// Assumes: sra_defs.svh holds every number except the state encodings, which stand here
// Notes:   none
package sra_pkg;
`include "sra_defs.svh"

   // gray along off, acquire, convert, done
   typedef enum logic [1:0] {
      SRA_OFF  = 2'h0,
      SRA_ACQ  = 2'h1,
      SRA_CONV = 2'h3,
      SRA_DONE = 2'h2
   } sra_state_t;

   typedef struct packed {
      logic data;
      logic oe_n;
   } sra_dout_t;

   typedef struct packed {
      logic                 track;
      logic [`SRA_RES_W-1:0] dac;
   } sra_th_t;

   typedef struct packed {
      logic acq_short;
      logic sclk_fast;
   } sra_flags_t;

endpackage

// >>> design/sra_sync.sv
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes:   stage one feeds stage two only
`timescale 1ns/10ps
module sra_sync #(
   parameter int              W       = 1,
   parameter logic [W-1:0]    RST_VAL = '0
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // levels
   input  wire logic [W-1:0]  d,
   output      logic [W-1:0]  q
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_q;

   always_comb begin
      nxt_meta = d;
      nxt_q    = meta_ff;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= RST_VAL;
         q_ff    <= RST_VAL;
      end else begin
         meta_ff <= nxt_meta;
         q_ff    <= nxt_q;
      end
   end

   assign q = q_ff;

endmodule

// >>> design/sra_readout.sv
// Purpose: sequencer and serial read port of a 14-bit successive-approximation converter
// Assumes: select and serial clock come from a host master; comparator is an async level
// Notes:   serial clock edges are found by sampling, so it must stay well below clk/2
//
// Notes on behaviour
// - select high keeps device shut down, idle
// - select low keeps converter fully powered
// - select falling edge wakes and starts acquisition
// - serial clock alone times conversion; max 4.8MHz
// - serial output changes only on clock falling edges
// - serial output high impedance while select high
// - eight zeros first, then result MSB first
// - result is 14-bit unipolar straight binary
// - sixth falling edge ends acquisition, freezes sample
// - track during acquisition, hold switches open after
// - hold mode steps DAC bit by bit
// - select high then low re-acquires afresh
// - readout spans twenty-four falling edges incl sub-bits
// - extra edges give zeros, converter undisturbed
// - select rising mid-conversion aborts into shutdown
// - select fall drives zero; data after eighth edge
`timescale 1ns/10ps
`include "sra_defs.svh"
module sra_readout
   import sra_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // host pins
   input  wire logic                  cs_n,
   input  wire logic                  sclk,
   output      sra_dout_t             dout,
   // analog front end
   input  wire logic                  comp_hi,
   output      sra_th_t               th,
   output      logic                  pwr_on,
   // result side
   output      logic [`SRA_RES_W-1:0] conv_word,
   output      logic [1:0]            sub_bits,
   output      logic                  word_valid,
   // host timing status
   output      sra_flags_t            flags
);

   // ----------------------------------------------------------------
   // pin synchronisers and edge finding
   // ----------------------------------------------------------------
   logic [2:0] pins_s;
   logic       cs_s;
   logic       sclk_s;
   logic       comp_s;
   logic       cs_d_ff;
   logic       sclk_d_ff;
   logic       nxt_cs_d;
   logic       nxt_sclk_d;
   logic       cs_fall;
   logic       cs_rise;
   logic       sclk_fall;

   sra_sync #(
      .W       (3),
      .RST_VAL (3'h4)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({cs_n, sclk, comp_hi}),
      .q   (pins_s)
   );

   assign cs_s   = pins_s[2];
   assign sclk_s = pins_s[1];
   assign comp_s = pins_s[0];

   always_comb begin
      nxt_cs_d   = cs_s;
      nxt_sclk_d = sclk_s;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cs_d_ff   <= 1'b1;
         sclk_d_ff <= 1'b0;
      end else begin
         cs_d_ff   <= nxt_cs_d;
         sclk_d_ff <= nxt_sclk_d;
      end
   end

   assign cs_fall   = cs_d_ff & ~cs_s;
   assign cs_rise   = ~cs_d_ff & cs_s;
   assign sclk_fall = sclk_d_ff & ~sclk_s;

   // ----------------------------------------------------------------
   // sequencer, successive approximation and serial output
   // ----------------------------------------------------------------
   sra_state_t              state_ff;
   sra_state_t              nxt_state;
   logic [`SRA_CNT_W-1:0]   cnt_ff;
   logic [`SRA_CNT_W-1:0]   nxt_cnt;
   logic [`SRA_RES_W-1:0]   dac_ff;
   logic [`SRA_RES_W-1:0]   nxt_dac;
   logic [`SRA_RES_W-1:0]   mask_ff;
   logic [`SRA_RES_W-1:0]   nxt_mask;
   logic                    track_ff;
   logic                    nxt_track;
   logic                    dec_ff;
   logic                    nxt_dec;
   sra_dout_t               dout_ff;
   sra_dout_t               nxt_dout;
   logic [`SRA_RES_W-1:0]   word_ff;
   logic [`SRA_RES_W-1:0]   nxt_word;
   logic [1:0]              sub_ff;
   logic [1:0]              nxt_sub;
   logic                    valid_ff;
   logic                    nxt_valid;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_dac   = dac_ff;
      nxt_mask  = mask_ff;
      nxt_track = track_ff;
      nxt_dec   = dec_ff;
      nxt_dout  = dout_ff;
      nxt_word  = word_ff;
      nxt_sub   = sub_ff;
      nxt_valid = 1'b0;
      if (cs_s) begin
         // shutdown also aborts any conversion under way
         nxt_state     = SRA_OFF;
         nxt_cnt       = '0;
         nxt_dac       = '0;
         nxt_mask      = '0;
         nxt_track     = 1'b0;
         nxt_dout.data = 1'b0;
         nxt_dout.oe_n = 1'b1;
      end else if (cs_fall) begin
         // fresh start: switches back to the input, output drives zero
         nxt_state     = SRA_ACQ;
         nxt_cnt       = '0;
         nxt_dac       = '0;
         nxt_mask      = '0;
         nxt_track     = 1'b1;
         nxt_dout.data = 1'b0;
         nxt_dout.oe_n = 1'b0;
      end else if (sclk_fall && state_ff != SRA_OFF) begin
         // only serial clock edges advance anything
         if (cnt_ff != `SRA_CNT_LAST) begin
            nxt_cnt = cnt_ff + 5'h01;
         end
         // output moves only here, one decision behind the comparator
         if (cnt_ff >= `SRA_CNT_OUT_LO && cnt_ff <= `SRA_CNT_OUT_HI) begin
            nxt_dout.data = dec_ff;
         end else begin
            nxt_dout.data = 1'b0;
         end
         case (state_ff)
            SRA_ACQ: begin
               if (cnt_ff == `SRA_CNT_SIXTH) begin
                  nxt_track = 1'b0;
                  nxt_state = SRA_CONV;
                  nxt_dac   = `SRA_DAC_MSB;
                  nxt_mask  = `SRA_DAC_MSB;
               end
            end
            SRA_CONV: begin
               nxt_dec = comp_s;
               if (cnt_ff <= `SRA_CNT_DEC_LSB) begin
                  // keep the trial bit if the input is above it
                  nxt_dac  = (comp_s ? dac_ff : (dac_ff & ~mask_ff)) | (mask_ff >> 1);
                  nxt_mask = mask_ff >> 1;
               end else if (cnt_ff == `SRA_CNT_SUB_HI) begin
                  nxt_sub[1] = comp_s;
                  nxt_word   = dac_ff;
               end else begin
                  nxt_sub[0] = comp_s;
                  nxt_state  = SRA_DONE;
                  nxt_valid  = 1'b1;
               end
            end
            SRA_DONE: begin
               // later edges leave the converter alone
               nxt_dec = 1'b0;
            end
            default: begin
               nxt_state = SRA_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= SRA_OFF;
         cnt_ff   <= '0;
         dac_ff   <= '0;
         mask_ff  <= '0;
         track_ff <= 1'b0;
         dec_ff   <= 1'b0;
         dout_ff  <= '{data: 1'b0, oe_n: 1'b1};
         word_ff  <= '0;
         sub_ff   <= '0;
         valid_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         dac_ff   <= nxt_dac;
         mask_ff  <= nxt_mask;
         track_ff <= nxt_track;
         dec_ff   <= nxt_dec;
         dout_ff  <= nxt_dout;
         word_ff  <= nxt_word;
         sub_ff   <= nxt_sub;
         valid_ff <= nxt_valid;
      end
   end

   assign dout       = dout_ff;
   assign th         = '{track: track_ff, dac: dac_ff};
   assign pwr_on     = (state_ff != SRA_OFF);
   assign conv_word  = word_ff;
   assign sub_bits   = sub_ff;
   assign word_valid = valid_ff;

   // ----------------------------------------------------------------
   // host timing monitor
   // ----------------------------------------------------------------
   // the host owes the acquisition time and clock rate; we only report
   logic [`SRA_ACQ_CNT_W-1:0] acq_cnt_ff;
   logic [`SRA_ACQ_CNT_W-1:0] nxt_acq_cnt;
   logic [`SRA_GAP_CNT_W-1:0] gap_ff;
   logic [`SRA_GAP_CNT_W-1:0] nxt_gap;
   sra_flags_t                flags_ff;
   sra_flags_t                nxt_flags;

   always_comb begin
      nxt_acq_cnt = acq_cnt_ff;
      nxt_gap     = gap_ff;
      nxt_flags   = flags_ff;
      if (cs_fall) begin
         nxt_acq_cnt = '0;
         nxt_gap     = '1;
         nxt_flags   = '0;
      end else if (!cs_s) begin
         if (acq_cnt_ff != '1) begin
            nxt_acq_cnt = acq_cnt_ff + 6'h01;
         end
         if (gap_ff != '1) begin
            nxt_gap = gap_ff + 4'h1;
         end
         if (sclk_fall) begin
            nxt_gap = '0;
            // sampled edges jitter one clk, so a legal clock may look one clk short
            if (gap_ff < `SRA_GAP_CNT_W'(`SRA_SCLK_MIN_CYC - 2)) begin
               nxt_flags.sclk_fast = 1'b1;
            end
            if (state_ff == SRA_ACQ && cnt_ff == `SRA_CNT_SIXTH &&
                acq_cnt_ff < `SRA_ACQ_CNT_W'(`SRA_ACQ_CYC - 2)) begin
               nxt_flags.acq_short = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         acq_cnt_ff <= '0;
         gap_ff     <= '1;
         flags_ff   <= '0;
      end else begin
         acq_cnt_ff <= nxt_acq_cnt;
         gap_ff     <= nxt_gap;
         flags_ff   <= nxt_flags;
      end
   end

   assign flags = flags_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_off_is_quiet: assert property (cs_s |=> state_ff == SRA_OFF && !pwr_on && !track_ff)
      else $error("device not shut down while select high");
   a_low_powered: assert property (!cs_s && !cs_fall && $past(!cs_s) |-> pwr_on)
      else $error("converter unpowered while select low");
   a_fall_wakes: assert property (cs_fall && !cs_s |=> state_ff == SRA_ACQ && cnt_ff == '0 && track_ff)
      else $error("select fall did not start acquisition");
   a_dout_on_fall: assert property (!cs_s && !$past(cs_fall) && $changed(dout_ff.data) |-> $past(sclk_fall))
      else $error("output changed away from a falling edge");
   a_hiz_when_high: assert property (cs_s |=> dout_ff.oe_n)
      else $error("output driven while select high");
   a_fall_drives_zero: assert property (cs_fall && !cs_s |=> !dout_ff.oe_n && !dout_ff.data)
      else $error("select fall did not drive zero");
   a_lead_zeros: assert property (state_ff != SRA_OFF && cnt_ff <= `SRA_CNT_OUT_LO |-> !dout_ff.data)
      else $error("leading zero missing");
   a_sixth_holds: assert property (sclk_fall && !cs_s && !cs_fall && state_ff == SRA_ACQ &&
                                   cnt_ff == `SRA_CNT_SIXTH |=> !track_ff && state_ff == SRA_CONV)
      else $error("acquisition did not end on sixth edge");
   a_track_in_acq: assert property (state_ff == SRA_ACQ |-> track_ff)
      else $error("track switch open during acquisition");
   a_hold_in_conv: assert property (state_ff == SRA_CONV |-> !track_ff)
      else $error("track switch closed during conversion");
   a_sar_step: assert property (sclk_fall && !cs_s && !cs_fall && state_ff == SRA_CONV &&
                                cnt_ff <= `SRA_CNT_DEC_LSB |=> mask_ff == ($past(mask_ff) >> 1))
      else $error("trial bit did not step");
   a_trailing_zero: assert property (cnt_ff == `SRA_CNT_LAST && !cs_s |-> !dout_ff.data && state_ff == SRA_DONE)
      else $error("trailing bit not zero");
   a_abort_resets: assert property (cs_rise |=> state_ff == SRA_OFF && cnt_ff == '0 && dout_ff.oe_n)
      else $error("abort did not reach shutdown");
   a_done_in_time: assert property (sclk_fall && !cs_s && !cs_fall && state_ff == SRA_CONV &&
                                    cnt_ff == `SRA_CNT_SUB_LO |=> word_valid && state_ff == SRA_DONE)
      else $error("conversion not finished on schedule");

endmodule

// >>> bench/sra_host_model.sv
// Purpose: host master model driving select and serial clock of the readout
// Assumes: 25 MHz clk; serial clock period 8 clk (320 ns), idle low
// Notes:   shifts the data pin in on serial clock rising edges
`timescale 1ns/10ps
module sra_host_model (
   // clock
   input  wire logic        clk,
   // request from the bench
   input  wire logic        go,
   input  wire logic [5:0]  nclk,
   output      logic        busy,
   output      logic [5:0]  falls,
   output      logic [31:0] rx,
   // pins
   output      logic        cs_n,
   output      logic        sclk,
   input  wire logic        dout_w
);
   int i;

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   initial begin
      cs_n  = 1'b1;
      sclk  = 1'b0;
      busy  = 1'b0;
      falls = 6'h00;
      rx    = 32'h0000_0000;
      forever begin
         @(posedge clk);
         if (go) begin
            busy  <= 1'b1;
            falls <= 6'h00;
            cs_n  <= 1'b0;
            repeat (4) @(posedge clk);
            // 4+44 clk to sixth fall, well over the 28 clk acquisition floor
            for (i = 0; i < nclk; i++) begin
               sclk <= 1'b1;
               rx   <= {rx[30:0], dout_w};
               repeat (4) @(posedge clk);
               sclk  <= 1'b0;
               falls <= falls + 6'h01;
               repeat (4) @(posedge clk);
            end
            cs_n <= 1'b1;
            // select stays high a while so the pin is released before the next frame
            repeat (4) @(posedge clk);
            busy <= 1'b0;
         end
      end
   end
endmodule

// >>> bench/tb_sra_readout.sv
// Purpose: self-checking bench of the serial readout sequencer
// Assumes: comparator modelled as held sample >= dac trial
// Notes:   data pin is resolved to z while the output enable is high
`timescale 1ns/10ps
`include "sra_defs.svh"
module tb_sra_readout
   import sra_pkg::*;
   ;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  cs_n;
   logic                  sclk;
   logic                  comp_hi;
   sra_dout_t             dout;
   sra_th_t               th;
   logic                  pwr_on;
   logic [`SRA_RES_W-1:0] conv_word;
   logic [1:0]            sub_bits;
   logic                  word_valid;
   sra_flags_t            flags;
   wire                   dout_w;
   logic                  go = 1'b0;
   logic [5:0]            nclk = 6'h18;
   logic                  busy;
   logic [5:0]            falls;
   logic [31:0]           rx;
   logic [13:0]           analog_input = 14'h0000;
   logic [13:0]           held_input = 14'h0000;
   logic                  sclk_q = 1'b0;
   logic                  prev_d = 1'b0;
   logic                  prev_oe = 1'b1;
   int                    since = 0;
   int                    cycles = 0;
   int                    wv_n = 0;
   int                    miscompares = 0;
   int                    checked = 0;

   always #20 clk = ~clk;
   assign dout_w  = dout.oe_n ? 1'bz : dout.data;
   assign comp_hi = (held_input >= th.dac);

   sra_readout sra_readout_inst (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .dout(dout),
      .comp_hi(comp_hi), .th(th), .pwr_on(pwr_on), .conv_word(conv_word), .sub_bits(sub_bits),
      .word_valid(word_valid), .flags(flags));
   sra_host_model sra_host_model_inst (.clk(clk), .go(go), .nclk(nclk), .busy(busy), .falls(falls),
      .rx(rx), .cs_n(cs_n), .sclk(sclk), .dout_w(dout_w));

   // ----------------------------------------
   // analog sample, pin monitor, timeout
   // ----------------------------------------
   always @(posedge clk) begin
      if (th.track === 1'b1) held_input <= analog_input;
      since   <= (sclk_q && !sclk) ? 1 : since + 1;
      sclk_q  <= sclk;
      prev_d  <= dout.data;
      prev_oe <= dout.oe_n;
      cycles  <= cycles + 1;
      if (word_valid === 1'b1) wv_n <= wv_n + 1;
      // data may only move two to four clk after a serial clock fall reaches the pin
      if (!rst && prev_oe === 1'b0 && dout.oe_n === 1'b0 && dout.data !== prev_d && (since < 2 || since > 4)) begin
         miscompares++;
         $display("CHECK FAILED at %0t: data moved %0h cycles %0h after fall", $time, dout.data, since);
      end
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic start(input logic [5:0] n);
      nclk <= n;
      go   <= 1'b1;
      @(posedge clk);
      go   <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_falls(input logic [5:0] k);
      for (int t = 0; t < 400 && falls < k; t++) @(posedge clk);
      chk(falls >= k, 1'b1);
      repeat (6) @(posedge clk);
   endtask

   task automatic wait_idle;
      for (int t = 0; t < 600 && busy; t++) @(posedge clk);
      chk(busy, 1'b0);
   endtask

   task automatic t_idle;
      chk(dout_w, 1'bz);
      chk(pwr_on, 1'b0);
      chk(th.track, 1'b0);
      $display("t_idle done");
   endtask

   task automatic t_conv(input logic [13:0] v);
      int w0;
      w0 = wv_n;
      analog_input <= v;
      start(6'h18);
      wait_falls(6'h05);
      chk(th.track, 1'b1);
      chk(pwr_on, 1'b1);
      chk(dout_w, 1'b0);
      wait_falls(6'h07);
      chk(th.track, 1'b0);
      analog_input <= ~v;
      wait_idle();
      chk(rx[23:16], 8'h00);
      chk(rx[15:2], v);
      chk(rx[1:0], 2'h3);
      chk(conv_word, v);
      chk(sub_bits, 2'h3);
      chk(wv_n - w0, 1);
      chk(flags, 2'h0);
      chk(dout_w, 1'bz);
      chk(pwr_on, 1'b0);
      $display("t_conv %h done", v);
   endtask

   task automatic t_extra;
      analog_input <= 14'h1234;
      start(6'h1c);
      wait_idle();
      chk(rx[27:20], 8'h00);
      chk(rx[19:6], 14'h1234);
      chk(rx[3:0], 4'h0);
      chk(conv_word, 14'h1234);
      $display("t_extra done");
   endtask

   task automatic t_abort;
      analog_input <= 14'h0abc;
      start(6'h0c);
      wait_idle();
      chk(conv_word, 14'h1234);
      chk(pwr_on, 1'b0);
      chk(th.track, 1'b0);
      chk(dout_w, 1'bz);
      t_conv(14'h0abc);
      $display("t_abort done");
   endtask

   task automatic end_of_test;
      $display("counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_idle();
      t_conv(14'h0000);
      t_conv(14'h3fff);
      t_conv(14'h2a55);
      t_extra();
      t_abort();
      end_of_test();
   end
endmodule
